// ### hdl/watchdog_timer_three.sv
// third timer: 16-bit general timer or watchdog with register port
//
// Behaviour
// - refresh write in watchdog mode restarts timeout
// - bit 8 sets count up, else down
// - bit 7 enables counting
// - bit 6 periodic reload, else free running
// - bit 5 enables watchdog reset action
// - bits 3-2 divide source by 1/16/256
// - bit 1 makes zero raise interrupt, not reset
// - bit 0 halts counting during peripheral powerdown
// - watchdog counts down from reload to zero
// - reload on overflow and on refresh write
// - watchdog mode locks reload and control writes
// - counter clocked from 32.768kHz tick, after prescaler
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module watchdog_timer_three
  import wdt3_pkg::*;
#(
  parameter int SRC_TICK_CYCLES = LP_TICK_CYCLES
) (
  input wire logic ref_clk_i, // 25 MHz system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic [31:0] addr_i, // register byte address
  input wire logic [15:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [15:0] power_control_reg_i, // power control bits
  output logic [15:0] rdata_o, // read data, cycle after strobe
  output logic wd_reset_o, // watchdog reset request, pulse
  output logic irq_o // interrupt request level
);
  // source divider is 16 bits wide, so longer periods cannot be served
  if (SRC_TICK_CYCLES < 1 || SRC_TICK_CYCLES > 65535) begin : g_bad_tick
    $error("source tick period must be 1 to 65535 cycles");
  end

  ctl_t watchdog_control_reg;
  logic [15:0] reload_value_reg;
  logic [15:0] counter_value_reg;
  logic timer_flag;
  logic wd_flag;
  logic wd_locked;
  logic pd_meta;
  logic pd_sync;
  logic src_tick;
  logic pre_tick;
  logic [8:0] pre_ratio;
  logic wr_reload;
  logic wr_control;
  logic wr_refresh;
  logic run;
  logic at_terminal;

  // ************************************************************
  // address decode
  // ************************************************************
  assign wr_reload = wr_i && (addr_i == RELOAD_OFFSET) && !wd_locked;
  assign wr_control = wr_i && (addr_i == CONTROL_OFFSET) && !wd_locked;
  // any data refreshes; a key check would need an unknown polynomial
  assign wr_refresh = wr_i && (addr_i == REFRESH_OFFSET);

  // ************************************************************
  // power control synchroniser
  // ************************************************************
  // powerdown bit comes from another block, treat it as asynchronous
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pd_meta <= 1'b0;
      pd_sync <= 1'b0;
    end else begin
      pd_meta <= power_control_reg_i[PWR_PD_BIT];
      pd_sync <= pd_meta;
    end
  end

  // ************************************************************
  // source tick and prescaler
  // ************************************************************
  // 32.768kHz stand-in tick derived from the system clock
  tick_divider #(.WIDTH(16)) u_src (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clear_i(1'b0),
    .tick_i(1'b1),
    .ratio_i(16'(SRC_TICK_CYCLES)),
    .tick_o(src_tick)
  );

  // reserved prescale code falls back to divide by one
  always_comb begin
    case (watchdog_control_reg.prescale)
      PRE_DIV16: pre_ratio = 9'(DIV16_COUNT);
      PRE_DIV256: pre_ratio = 9'(DIV256_COUNT);
      default: pre_ratio = 9'h001;
    endcase
  end

  tick_divider #(.WIDTH(9)) u_pre (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clear_i(wr_control),
    .tick_i(src_tick),
    .ratio_i(pre_ratio),
    .tick_o(pre_tick)
  );

  // ************************************************************
  // configuration registers
  // ************************************************************
  // reserved bits 15-9 and 4 are dropped on write
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      watchdog_control_reg <= ctl_t'(8'h00);
    end else if (wr_control) begin
      watchdog_control_reg <= {wdata_i[CTL_UP_BIT:CTL_WD_BIT],
                               wdata_i[CTL_PRE_LSB+1:0]};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reload_value_reg <= RELOAD_RESET;
    end else if (wr_reload) begin
      reload_value_reg <= wdata_i;
    end
  end

  // lock only released by reset, so a stuck program cannot escape
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wd_locked <= 1'b0;
    end else if (watchdog_control_reg.watchdog) begin
      wd_locked <= 1'b1;
    end
  end

  // ************************************************************
  // counter
  // ************************************************************
  assign run = watchdog_control_reg.enable && pre_tick
    && !(watchdog_control_reg.powerdown_halt_select && pd_sync);
  // watchdog always counts down; up counting only in timer mode
  assign at_terminal = watchdog_control_reg.watchdog
    ? (counter_value_reg == 16'h0000)
    : (watchdog_control_reg.count_up ? (counter_value_reg == 16'hFFFF)
                                     : (counter_value_reg == 16'h0000));

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      counter_value_reg <= VALUE_RESET;
    end else if (wr_refresh) begin
      counter_value_reg <= reload_value_reg;
    end else if (run) begin
      if (at_terminal) begin
        if (watchdog_control_reg.watchdog
            || watchdog_control_reg.periodic) begin
          counter_value_reg <= reload_value_reg;
        end else if (watchdog_control_reg.count_up) begin
          counter_value_reg <= 16'h0000;
        end else begin
          counter_value_reg <= 16'hFFFF;
        end
      end else if (watchdog_control_reg.count_up
                   && !watchdog_control_reg.watchdog) begin
        counter_value_reg <= counter_value_reg + 16'h0001;
      end else begin
        counter_value_reg <= counter_value_reg - 16'h0001;
      end
    end
  end

  // ************************************************************
  // events: flags, reset pulse
  // ************************************************************
  // terminal event beats a refresh in the same cycle for the timer flag; refresh wins for wd_flag and the reset pulse
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      timer_flag <= 1'b0;
      wd_flag <= 1'b0;
    end else begin
      if (run && at_terminal && !watchdog_control_reg.watchdog) begin
        timer_flag <= 1'b1;
      end else if (wr_refresh) begin
        timer_flag <= 1'b0;
      end
      if (run && at_terminal && watchdog_control_reg.watchdog
          && watchdog_control_reg.irq_select && !wr_refresh) begin
        wd_flag <= 1'b1;
      end else if (wr_refresh) begin
        wd_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wd_reset_o <= 1'b0;
    end else begin
      wd_reset_o <= run && at_terminal && !wr_refresh
        && watchdog_control_reg.watchdog
        && !watchdog_control_reg.irq_select;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= timer_flag || wd_flag;
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  // unmapped and write-only addresses read zero
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        RELOAD_OFFSET: rdata_o <= reload_value_reg;
        VALUE_OFFSET: rdata_o <= counter_value_reg;
        CONTROL_OFFSET: rdata_o <= {7'h00, watchdog_control_reg[7:4],
                                    1'b0, watchdog_control_reg[3:0]};
        STATUS_OFFSET: rdata_o <= {13'h0000, wd_locked, wd_flag,
                                   timer_flag};
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end
endmodule : watchdog_timer_three
`default_nettype wire

// ### shared/wdt3_pkg.sv
// package: register map, control fields and constants of the watchdog timer
package wdt3_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [31:0] RELOAD_OFFSET = 32'hFFFF0360;
  localparam logic [31:0] VALUE_OFFSET = 32'hFFFF0364;
  localparam logic [31:0] CONTROL_OFFSET = 32'hFFFF0368;
  localparam logic [31:0] REFRESH_OFFSET = 32'hFFFF036C;
  localparam logic [31:0] STATUS_OFFSET = 32'hFFFF0370;
  // ************************************************************
  // control field positions
  // ************************************************************
  localparam int CTL_UP_BIT = 8;
  localparam int CTL_EN_BIT = 7;
  localparam int CTL_PER_BIT = 6;
  localparam int CTL_WD_BIT = 5;
  localparam int CTL_PRE_LSB = 2;
  localparam int CTL_IRQ_BIT = 1;
  localparam int CTL_PDH_BIT = 0;
  localparam int PWR_PD_BIT = 4;
  localparam logic [15:0] CTL_WRITE_MASK = 16'h01EF;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h03D7;
  localparam logic [15:0] VALUE_RESET = 16'h03D7;
  // ************************************************************
  // prescaler codes and divide counts
  // ************************************************************
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV16 = 2'h1;
  localparam logic [1:0] PRE_DIV256 = 2'h2;
  localparam int DIV16_COUNT = 16;
  localparam int DIV256_COUNT = 256;
  // ************************************************************
  // clocks: system clock and low-power source tick
  // ************************************************************
  localparam real REF_CLK_HZ = 25.0e6;
  localparam real LP_OSC_HZ = 32768.0;
  localparam int LP_TICK_CYCLES = int'(REF_CLK_HZ / LP_OSC_HZ);
  // ************************************************************
  // control register as a struct
  // ************************************************************
  typedef struct packed {
    logic count_up;
    logic enable;
    logic periodic;
    logic watchdog;
    logic [1:0] prescale;
    logic irq_select;
    logic powerdown_halt_select;
  } ctl_t;
endpackage : wdt3_pkg

// ### hdl/tick_divider.sv
// divider that turns a clock enable into a slower one-cycle enable
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic clear_i, // restart the division
  input wire logic tick_i, // input enable
  input wire logic [WIDTH-1:0] ratio_i, // divide ratio, 1 passes through
  output logic tick_o // divided enable
);
  logic [WIDTH-1:0] count;
  // a zero-width counter cannot hold any ratio
  if (WIDTH < 1) begin : g_bad_width
    $error("divider width must be at least one bit");
  end
  // ************************************************************
  // counting
  // ************************************************************
  // ratio of zero behaves as one so the tick never disappears
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || clear_i) begin
      count <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (tick_i) begin
        if (count + 1'b1 >= ratio_i) begin
          count <= '0;
          tick_o <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end
endmodule : tick_divider
`default_nettype wire

// ### verification/wdt3_sva.sv
// checker: port-level properties of the watchdog timer
`timescale 1ns/10ps
`default_nettype none
module wdt3_sva
  import wdt3_pkg::*;
(
  input wire logic ref_clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic [31:0] addr_i, // address
  input wire logic [15:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [15:0] power_control_reg_i, // power bits
  input wire logic [15:0] rdata_o, // read data
  input wire logic wd_reset_o, // reset request
  input wire logic irq_o // interrupt
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ************************************************************
  // bus steps
  // ************************************************************
  sequence s_rd(a);
    rd_i && addr_i == a;
  endsequence
  sequence s_refresh;
    wr_i && addr_i == REFRESH_OFFSET;
  endsequence
  // ************************************************************
  // properties
  // ************************************************************
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data not zero outside answer");
  a_unmapped_zero: assert property (s_rd(32'hFFFF0374) |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_refresh_wo: assert property (s_rd(REFRESH_OFFSET) |=> rdata_o == 16'h0000)
    else $error("refresh register readable");
  a_ctrl_reserved: assert property (s_rd(CONTROL_OFFSET) |=>
    (rdata_o & ~CTL_WRITE_MASK) == 16'h0000) else $error("reserved bits set");
  a_status_reserved: assert property (s_rd(STATUS_OFFSET) |=>
    rdata_o[15:3] == 13'h0000) else $error("status upper bits set");
  a_reset_pulse: assert property (wd_reset_o |=> !wd_reset_o)
    else $error("reset request longer than a cycle");
  a_refresh_saves: assert property (s_refresh |=> !wd_reset_o)
    else $error("reset request after refresh");
  a_refresh_clears: assert property (s_refresh |-> ##2 !irq_o)
    else $error("interrupt stays after refresh");
  a_reset_quiet: assert property ($fell(rst_i) |->
    !wd_reset_o && !irq_o && rdata_o == 16'h0000) else $error("outputs set");
endmodule : wdt3_sva
`default_nettype wire

// ### verification/test_watchdog_timer_three.sv
// testbench: register-level scenarios for the watchdog timer
`timescale 1ns/10ps
`default_nettype none
module test_watchdog_timer_three
  import wdt3_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] addr_i = 32'h0;
  logic [15:0] wdata_i = 16'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] power_control_reg_i = 16'h0;
  logic [15:0] rdata_o;
  logic wd_reset_o;
  logic irq_o;
  logic [15:0] v;
  int mismatches = 0;
  int checked = 0;
  int pulses = 0;
  int k;
  // tiny source period keeps the run short
  watchdog_timer_three #(.SRC_TICK_CYCLES(2)) u_dut (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .power_control_reg_i(power_control_reg_i),
    .rdata_o(rdata_o), .wd_reset_o(wd_reset_o), .irq_o(irq_o));
  always #20 ref_clk_i = ~ref_clk_i;
  // count reset requests, pulses last one cycle
  always @(posedge ref_clk_i) if (wd_reset_o === 1'b1) pulses++;
  // ************************************************************
  // shared tasks
  // ************************************************************
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [31:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task rchk(input logic [31:0] a, input logic [15:0] exp);
    rd(a, v);
    check(v, exp);
  endtask : rchk
  task do_reset;
    rst_i <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
  endtask : do_reset
  // bounded wait, a timeout ends the run
  task wait_irq(input logic lvl);
    int i;
    for (i = 0; i < 200 && irq_o !== lvl; i++) @(posedge ref_clk_i);
    check({15'h0, irq_o}, {15'h0, lvl});
    if (irq_o !== lvl) test_done;
  endtask : wait_irq
  // steps counted over 600 cycles must fall in lo..hi
  task run(input logic [15:0] ctl, input logic pd, input int lo,
    input int hi);
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] dd;
    power_control_reg_i <= {11'h0, pd, 4'h0};
    wr(RELOAD_OFFSET, 16'h8000);
    wr(REFRESH_OFFSET, 16'h0000);
    wr(CONTROL_OFFSET, ctl);
    rd(VALUE_OFFSET, a);
    repeat (600) @(posedge ref_clk_i);
    rd(VALUE_OFFSET, b);
    wr(CONTROL_OFFSET, 16'h0000);
    dd = ctl[8] ? b - a : a - b;
    check({15'h0, dd >= lo && dd <= hi}, 16'h0001);
  endtask : run
  // ************************************************************
  // scenarios
  // ************************************************************
  task t_defaults;
    rchk(CONTROL_OFFSET, CONTROL_RESET);
    rchk(RELOAD_OFFSET, RELOAD_RESET);
    repeat (50) @(posedge ref_clk_i);
    rchk(VALUE_OFFSET, VALUE_RESET);
    rchk(32'hFFFF0374, 16'h0000);
    rchk(REFRESH_OFFSET, 16'h0000);
    // every bit set except watchdog, so bit 8 is read back too
    wr(CONTROL_OFFSET, 16'hFFDF);
    rchk(CONTROL_OFFSET, 16'h01CF);
    wr(CONTROL_OFFSET, 16'h0000);
  endtask : t_defaults
  task t_rate;
    int lo_t[4] = '{295, 16, 0, 295};
    int hi_t[4] = '{302, 20, 3, 302};
    for (k = 0; k < 4; k++) begin
      run(16'h0180 | 16'(k << 2), 1'b0, lo_t[k], hi_t[k]);
    end
    run(16'h0080, 1'b0, 295, 302);
    run(16'h0181, 1'b1, 0, 0);
    run(16'h0180, 1'b1, 295, 302);
    power_control_reg_i <= 16'h0000;
  endtask : t_rate
  task t_periodic;
    wr(RELOAD_OFFSET, 16'h0005);
    wr(REFRESH_OFFSET, 16'h0000);
    wr(CONTROL_OFFSET, 16'h00C0);
    wait_irq(1'b1);
    rd(VALUE_OFFSET, v);
    check({15'h0, v <= 16'h0005}, 16'h0001);
    // stop first so no terminal count meets the refresh
    wr(CONTROL_OFFSET, 16'h0000);
    wr(REFRESH_OFFSET, 16'h0000);
    @(posedge ref_clk_i);
    #1 check({15'h0, irq_o}, 16'h0000);
    wr(CONTROL_OFFSET, 16'h0080);
    repeat (30) @(posedge ref_clk_i);
    rd(VALUE_OFFSET, v);
    check({15'h0, v > 16'h0005}, 16'h0001);
    wr(CONTROL_OFFSET, 16'h0000);
    check(16'(pulses), 16'h0000);
  endtask : t_periodic
  task t_watchdog;
    do_reset;
    wr(RELOAD_OFFSET, 16'h0004);
    wr(CONTROL_OFFSET, 16'h00A0);
    repeat (10) wr(REFRESH_OFFSET, 16'h1234);
    check(16'(pulses), 16'h0000);
    wr(CONTROL_OFFSET, 16'h0000);
    wr(RELOAD_OFFSET, 16'h0100);
    rchk(CONTROL_OFFSET, 16'h00A0);
    rchk(RELOAD_OFFSET, 16'h0004);
    rd(VALUE_OFFSET, v);
    check({15'h0, v <= 16'h0004}, 16'h0001);
    for (k = 0; k < 100 && pulses == 0; k++) @(posedge ref_clk_i);
    check({15'h0, pulses > 0}, 16'h0001);
    if (pulses == 0) test_done;
    check({15'h0, irq_o}, 16'h0000);
    do_reset;
    wr(RELOAD_OFFSET, 16'h0004);
    // counter restarts from its reset value, load the short timeout
    wr(REFRESH_OFFSET, 16'h0000);
    wr(CONTROL_OFFSET, 16'h00A2);
    k = pulses;
    wait_irq(1'b1);
    check(16'(pulses - k), 16'h0000);
    rd(STATUS_OFFSET, v);
    check(v & 16'h0006, 16'h0006);
  endtask : t_watchdog
  initial begin
    do_reset;
    t_defaults;
    t_rate;
    t_periodic;
    t_watchdog;
    test_done;
  end
endmodule : test_watchdog_timer_three
bind watchdog_timer_three wdt3_sva u_sva (.ref_clk_i(ref_clk_i),
  .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .power_control_reg_i(power_control_reg_i),
  .rdata_o(rdata_o), .wd_reset_o(wd_reset_o), .irq_o(irq_o));
`default_nettype wire
